// ===== verilog/power_down_mode_control.sv
// power-down mode controller with Avalon-MM register slave
`timescale 1ns/1ps
module power_down_mode_control
  import pdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // avalon-mm slave, byte address
  input wire logic [21:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // cpu side, same clock
  input wire logic i_halt_instr,
  input wire wake_s i_wake,
  input wire logic i_port6_bit7_clk,
  // pins, asynchronous
  input wire logic i_standby_pin_n,
  input wire logic i_power_on_clear_n,
  // controls
  output pwr_mode_e o_mode,
  output pwr_ctl_s o_ctl,
  output logic [NUM_MODULES-1:0] o_module_halt,
  output logic [NUM_MODULES-1:0] o_module_init,
  output logic o_refresh_init,
  output logic o_internal_ram_enable
);
  typedef struct packed {
    logic [1:0] standby_pin_n_sync;
    logic [1:0] por_sync;
    pwr_mode_e mode;
    logic [7:0] sys_ctl;
    logic [7:0] halt_hi;
    logic [7:0] halt_lo;
    logic waking;
    logic ack;
    logic waitreq;
    logic [31:0] rdata;
    pwr_ctl_s ctl;
    logic [NUM_MODULES-1:0] mod_halt;
    logic [NUM_MODULES-1:0] mod_init;
    logic refresh_init;
  } state_s;
  state_s st;
  state_s next_st;

  logic tmr_busy;
  logic tmr_done;
  logic tmr_load;
  logic tmr_abort;
  logic [2:0] wait_code;
  logic standby_pin_n_low;
  logic por_low;
  logic [NUM_MODULES-1:0] halt_bits;
  logic [7:0] wbyte;
  logic hit_sys;
  logic hit_hi;
  logic hit_lo;
  logic wr_go;

  // ****************************************************************
  // pin synchronisers, only the second stage is read by logic
  // ****************************************************************
  assign standby_pin_n_low = ~st.standby_pin_n_sync[1];
  assign por_low = ~st.por_sync[1];

  assign wait_code = st.sys_ctl[SYS_WAIT_LSB +: 3];
  assign halt_bits = {st.halt_hi, st.halt_lo};

  // ****************************************************************
  // bus decode: each register sits in byte lane 0 at byte address 4 * index
  // ****************************************************************
  assign hit_sys = (i_address == BYTE_SYS_CTL);
  assign hit_hi = (i_address == BYTE_HALT_HI);
  assign hit_lo = (i_address == BYTE_HALT_LO);
  assign wbyte = i_writedata[7:0];
  // one wait cycle per access; the ack cycle completes it
  assign wr_go = i_write && st.ack && i_byteenable[0];

  // wake timer starts on an external wake out of software standby
  assign tmr_abort = standby_pin_n_low || por_low;
  assign tmr_load = (st.mode == MODE_SW_STANDBY_PIN_N) && !st.waking && !tmr_busy && !tmr_abort
    && (i_wake.nmi || (|i_wake.ext_irq));

  pdc_wake_timer #(
    .W(WAIT_CNT_W)
  ) u_wake_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(tmr_load),
    .i_abort(tmr_abort),
    .i_count(wait_states(wait_code)),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.standby_pin_n_sync = {st.standby_pin_n_sync[0], i_standby_pin_n};
    next_st.por_sync = {st.por_sync[0], i_power_on_clear_n};
    next_st.ack = (i_read || i_write) && !st.ack;
    // waitrequest idles high so it can come straight from a flop
    next_st.waitreq = !next_st.ack;
    next_st.mod_init = '0;
    next_st.refresh_init = 1'b0;

    // register reads stand with the ack cycle
    if ((i_read || i_write) && !st.ack) begin
      next_st.rdata = 32'h0000_0000;
      if (hit_sys) begin
        next_st.rdata[7:0] = st.sys_ctl;
      end else if (hit_hi) begin
        next_st.rdata[7:0] = st.halt_hi | HI_FIXED_ONES;
      end else if (hit_lo) begin
        next_st.rdata[7:0] = st.halt_lo;
      end
    end

    // register writes; the standby select bit changes only by write, by system reset or by the power-on clear and standby pin resets
    if (wr_go) begin
      if (hit_sys) begin
        next_st.sys_ctl = wbyte;
      end
      if (hit_hi) begin
        next_st.halt_hi = wbyte | HI_FIXED_ONES;
      end
      if (hit_lo) begin
        next_st.halt_lo = wbyte;
      end
    end

    // rising halt bits reinitialise their modules
    // clock stop bit is not a module, so it never pulses an init
    next_st.mod_init = {next_st.halt_hi, next_st.halt_lo} & ~halt_bits & 16'h07FF;
    // dram interface sits at low bit 5
    if (next_st.mod_init[5]) begin
      next_st.refresh_init = 1'b1;
    end

    // mode sequencing
    case (st.mode)
      MODE_RUN: begin
        if (i_halt_instr) begin
          if (st.sys_ctl[SYS_SSEL_BIT]) begin
            next_st.mode = MODE_SW_STANDBY_PIN_N;
            next_st.refresh_init = 1'b1;
          end else begin
            next_st.mode = MODE_SLEEP;
          end
        end
      end
      MODE_SLEEP: begin
        if (i_wake.any_irq || i_wake.nmi || (|i_wake.ext_irq)) begin
          next_st.mode = MODE_RUN;
        end
      end
      MODE_SW_STANDBY_PIN_N: begin
        if (tmr_load) begin
          next_st.waking = 1'b1;
        end
        if (tmr_done) begin
          next_st.mode = MODE_RUN;
          next_st.waking = 1'b0;
        end
      end
      MODE_HW_STANDBY_PIN_N: begin
        if (!standby_pin_n_low) begin
          next_st.mode = MODE_RUN;
        end
      end
      default: begin
        next_st.mode = MODE_RUN;
      end
    endcase

    // power-on clear and standby pin win over everything
    if (por_low && !standby_pin_n_low) begin
      next_st.mode = MODE_RUN;
      next_st.waking = 1'b0;
      next_st.sys_ctl = RST_SYS_CTL;
      next_st.halt_hi = RST_HALT_HI;
      next_st.halt_lo = RST_HALT_LO;
    end
    if (standby_pin_n_low) begin
      next_st.mode = MODE_HW_STANDBY_PIN_N;
      next_st.waking = 1'b0;
      next_st.sys_ctl = RST_SYS_CTL;
      next_st.halt_hi = RST_HALT_HI;
      next_st.halt_lo = RST_HALT_LO;
      next_st.mod_init = '0;
    end

    // halts follow bits in every mode, cpu keeps running
    next_st.mod_halt = {5'b00000, next_st.halt_hi[2:0], next_st.halt_lo};

    // per-mode controls
    next_st.ctl = '0;
    case (next_st.mode)
      MODE_SLEEP: begin
        next_st.ctl.cpu_halt = 1'b1;
      end
      MODE_SW_STANDBY_PIN_N: begin
        next_st.ctl.cpu_halt = 1'b1;
        next_st.ctl.clk_stop = 1'b1;
        next_st.ctl.periph_reset = 1'b1;
        next_st.ctl.clk_out_high = i_port6_bit7_clk;
        next_st.ctl.bus_hiz = !next_st.sys_ctl[SYS_KEEP_BIT];
        next_st.ctl.bus_ctl_high = next_st.sys_ctl[SYS_KEEP_BIT];
      end
      MODE_HW_STANDBY_PIN_N: begin
        next_st.ctl.cpu_halt = 1'b1;
        next_st.ctl.clk_stop = 1'b1;
        next_st.ctl.periph_reset = 1'b1;
        next_st.ctl.regs_lost = 1'b1;
        next_st.ctl.io_hiz = 1'b1;
        next_st.ctl.bus_hiz = 1'b1;
        next_st.ctl.clk_out_hiz = i_port6_bit7_clk;
      end
      default: begin
        next_st.ctl = '0;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.standby_pin_n_sync <= 2'b11;
      st.por_sync <= 2'b11;
      st.mode <= MODE_RUN;
      st.sys_ctl <= RST_SYS_CTL;
      st.halt_hi <= RST_HALT_HI;
      st.halt_lo <= RST_HALT_LO;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs, all from flops
  // ****************************************************************
  assign o_readdata = st.rdata;
  assign o_waitrequest = st.waitreq;
  assign o_mode = st.mode;
  assign o_ctl = st.ctl;
  assign o_module_halt = st.mod_halt;
  assign o_module_init = st.mod_init;
  assign o_refresh_init = st.refresh_init;
  // software clears this before pulling the standby pin
  assign o_internal_ram_enable = st.sys_ctl[SYS_INTERNAL_RAM_ENABLE_BIT];
endmodule : power_down_mode_control

// ===== shared/pdc_pkg.sv
// package: register map, field layout and timing for the power-down controller
// ****************************************************************
// Functional notes
// - halt with select clear enters sleep
// - halt with select set enters software standby
// - standby wakes only on nmi, ext0-2, pin, power-on clear
// - low standby pin forces hardware standby
// - dram halts, refresh counter/ctl bits cleared
// - module halts independent of power-down modes
// - set halt bit stops and resets module
// - setting halt bit initialises module registers
// - three byte registers, resets 09, 78, 00
// - select bit stays set after wake
// - wake waits selected states, code 111 illegal
// - output keep bit picks hold or high-z
// ****************************************************************
package pdc_pkg;
  // register offsets, used as word indices on the bus
  localparam logic [19:0] ADDR_SYS_CTL = 20'hEE012;
  localparam logic [19:0] ADDR_HALT_HI = 20'hEE01C;
  localparam logic [19:0] ADDR_HALT_LO = 20'hEE01D;
  // offsets are not byte addresses but indices: byte address = 4 * index
  localparam logic [21:0] BYTE_SYS_CTL = {ADDR_SYS_CTL, 2'b00};
  localparam logic [21:0] BYTE_HALT_HI = {ADDR_HALT_HI, 2'b00};
  localparam logic [21:0] BYTE_HALT_LO = {ADDR_HALT_LO, 2'b00};
  localparam logic [7:0] RST_SYS_CTL = 8'h09;
  localparam logic [7:0] RST_HALT_HI = 8'h78;
  localparam logic [7:0] RST_HALT_LO = 8'h00;
  // field positions in system_control_reg
  localparam int SYS_SSEL_BIT = 7;
  localparam int SYS_WAIT_LSB = 4;
  localparam int SYS_KEEP_BIT = 1;
  localparam int SYS_INTERNAL_RAM_ENABLE_BIT = 0;
  // module_halt_reg_high: bit7 clock stop, 6..3 read as one
  localparam int HI_CLK_STOP_BIT = 7;
  localparam logic [7:0] HI_FIXED_ONES = 8'h78;
  localparam int NUM_MODULES = 16;
  localparam logic [2:0] WAIT_ILLEGAL = 3'h7;
  localparam int WAIT_CNT_W = 19;

  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_SW_STANDBY_PIN_N, MODE_HW_STANDBY_PIN_N} pwr_mode_e;

  // wake sources from the interrupt side
  typedef struct packed {
    logic any_irq;
    logic nmi;
    logic [2:0] ext_irq;
  } wake_s;

  // per-mode outputs to the rest of the chip
  typedef struct packed {
    logic cpu_halt;
    logic clk_stop;
    logic periph_reset;
    logic regs_lost;
    logic io_hiz;
    logic bus_hiz;
    logic bus_ctl_high;
    logic clk_out_high;
    logic clk_out_hiz;
  } pwr_ctl_s;

  // states per wait code 0..6
  function automatic logic [WAIT_CNT_W-1:0] wait_states(input logic [2:0] code);
    case (code)
      3'h0: wait_states = 19'd8192;
      3'h1: wait_states = 19'd16384;
      3'h2: wait_states = 19'd32768;
      3'h3: wait_states = 19'd65536;
      3'h4: wait_states = 19'd131072;
      3'h5: wait_states = 19'd262144;
      3'h6: wait_states = 19'd1024;
      default: wait_states = 19'd8192;
    endcase
  endfunction : wait_states
endpackage : pdc_pkg

// ===== verilog/pdc_wake_timer.sv
// wake settle timer: counts a loaded number of states down to zero
`timescale 1ns/1ps
module pdc_wake_timer
  import pdc_pkg::*;
#(
  parameter int W = WAIT_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic i_abort,
  input wire logic [W-1:0] i_count,
  output logic o_busy,
  output logic o_done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_s;
  tmr_s st;
  tmr_s next_st;

  // ****************************************************************
  // countdown
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (i_abort) begin
      next_st.busy = 1'b0;
    end else if (i_load) begin
      next_st.cnt = i_count - W'(1);
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1; // pulse after i_count states
      end else begin
        next_st.cnt = st.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_busy = st.busy;
  assign o_done = st.done;
endmodule : pdc_wake_timer

// ===== tb/pdc_props.sv
// port checker for the power-down controller
`timescale 1ns/1ps
module pdc_props
  import pdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic i_halt_instr,
  input wire wake_s i_wake,
  input wire logic i_standby_pin_n,
  input wire pwr_mode_e o_mode,
  input wire pwr_ctl_s o_ctl,
  input wire logic [NUM_MODULES-1:0] o_module_halt,
  input wire logic [NUM_MODULES-1:0] o_module_init,
  input wire logic o_internal_ram_enable
);
  // ****************************************
  // helper state and properties
  // ****************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [1:0] pin_hi;
  logic woke;
  logic [10:0] wcnt;
  // pin must be high through the sync stages before a halt is judged
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_standby_pin_n) begin
      pin_hi <= 2'h0;
    end else if (pin_hi != 2'h3) begin
      pin_hi <= pin_hi + 2'h1;
    end
  end
  // wake seen in standby, and cycles since, saturating at 1024
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || o_mode != MODE_SW_STANDBY_PIN_N) begin
      woke <= 1'b0;
      wcnt <= 11'h000;
    end else begin
      woke <= woke | i_wake.nmi | (|i_wake.ext_irq);
      wcnt <= (woke && !wcnt[10]) ? wcnt + 11'h001 : wcnt;
    end
  end
  sequence pin_low_s;
    (!i_standby_pin_n) [*4];
  endsequence
  sequence sw_exit_s;
    $past(o_mode) == MODE_SW_STANDBY_PIN_N && o_mode == MODE_RUN;
  endsequence
  chk_bus_first: assert property ($rose(i_read) |-> o_waitrequest)
    else $error("read not held off first cycle");
  chk_bus_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("no answer in second cycle");
  chk_halt_entry: assert property (i_halt_instr && o_mode == MODE_RUN && pin_hi == 2'h3
    |=> o_mode inside {MODE_SLEEP, MODE_SW_STANDBY_PIN_N})
    else $error("halt did not enter a low power mode");
  chk_pin_force: assert property (pin_low_s |-> o_mode == MODE_HW_STANDBY_PIN_N)
    else $error("low pin did not force hardware standby");
  chk_hw_outputs: assert property (o_mode == MODE_HW_STANDBY_PIN_N |-> o_ctl.io_hiz && o_ctl.regs_lost
    && o_ctl.clk_stop && o_ctl.periph_reset)
    else $error("hardware standby controls wrong");
  chk_sw_outputs: assert property (o_mode == MODE_SW_STANDBY_PIN_N |-> o_ctl.clk_stop && o_ctl.cpu_halt
    && o_ctl.periph_reset && !o_ctl.io_hiz && (o_ctl.bus_hiz != o_ctl.bus_ctl_high))
    else $error("software standby controls wrong");
  chk_sleep_outputs: assert property (o_mode == MODE_SLEEP |-> o_ctl.cpu_halt
    && !o_ctl.clk_stop && !o_ctl.periph_reset)
    else $error("sleep controls wrong");
  chk_wake_source: assert property (sw_exit_s |-> woke)
    else $error("standby left without a legal wake");
  chk_wake_wait: assert property (sw_exit_s |-> wcnt >= 11'd1000)
    else $error("standby left before settle time");
  chk_init_halt: assert property (o_module_init != '0 |-> (o_module_init & ~o_module_halt) == '0)
    else $error("init pulse without halt bit");
  chk_reset_vals: assert property ($fell(i_sys_rst) |-> o_mode == MODE_RUN && o_ctl == '0
    && o_internal_ram_enable)
    else $error("state after reset wrong");
endmodule : pdc_props

bind power_down_mode_control pdc_props u_props (.i_clk, .i_sys_rst, .i_read, .i_write,
  .o_waitrequest, .i_halt_instr, .i_wake, .i_standby_pin_n, .o_mode, .o_ctl, .o_module_halt,
  .o_module_init, .o_internal_ram_enable);

// ===== tb/cpu_side_model.sv
// cpu core stand-in: halt pulse and interrupt levels
`timescale 1ns/1ps
module cpu_side_model
  import pdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_do_halt,
  input wire wake_s i_wake_req,
  output logic o_halt,
  output wake_s o_wake
);
  // one register stage, as a core issues its strobes from flops
  always_ff @(posedge i_clk) begin
    o_halt <= i_do_halt;
    o_wake <= i_wake_req;
  end
endmodule : cpu_side_model

// ===== tb/tb_top.sv
// self-checking bench for the power-down controller
`timescale 1ns/1ps
module tb_top;
  import pdc_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [21:0] adr = '0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdat = '0;
  logic [3:0] ben = 4'hF;
  logic [31:0] rdat;
  logic wait_r;
  logic halt_req = 1'b0;
  logic halt_p;
  wake_s wake_req = '0;
  wake_s wake_l;
  logic pin_n = 1'b1;
  logic p6clk = 1'b1;
  pwr_mode_e mode;
  pwr_ctl_s ctl;
  logic [15:0] mhalt;
  logic [15:0] minit;
  logic [15:0] init_seen = '0;
  logic refr;
  logic refr_seen = 1'b0;
  logic ram_en;
  logic [15:0] rd;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  power_down_mode_control DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(adr),
    .i_read(rd_s), .i_write(wr_s), .i_writedata(wdat), .i_byteenable(ben),
    .o_readdata(rdat), .o_waitrequest(wait_r), .i_halt_instr(halt_p), .i_wake(wake_l),
    .i_port6_bit7_clk(p6clk), .i_standby_pin_n(pin_n), .i_power_on_clear_n(1'b1),
    .o_mode(mode), .o_ctl(ctl), .o_module_halt(mhalt), .o_module_init(minit),
    .o_refresh_init(refr), .o_internal_ram_enable(ram_en));
  cpu_side_model u_cpu (.i_clk(i_clk), .i_do_halt(halt_req), .i_wake_req(wake_req),
    .o_halt(halt_p), .o_wake(wake_l));
  // ****************************************
  // clock, timeout, pulse capture
  // ****************************************
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // pulses are one cycle wide, so latch them rather than race the edge
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    init_seen <= init_seen | minit;
    refr_seen <= refr_seen | refr;
    if (cyc == 12000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_mode(input pwr_mode_e exp);
    n = 0;
    while (mode !== exp && n < 60) begin
      @(posedge i_clk);
      n++;
    end
    checks++;
    if (mode !== exp) begin
      error_cnt++;
      $display("BAD %0t mode %0d expected %0d", $time, mode, exp);
    end
  endtask : check_mode
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [21:0] a, input logic [7:0] d);
    @(posedge i_clk);
    adr <= a;
    rd_s <= !wr;
    wr_s <= wr;
    wdat <= {24'h000000, d};
    @(posedge i_clk);
    while (wait_r !== 1'b0) @(posedge i_clk);
    rd = {8'h00, rdat[7:0]};
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask : bus
  task automatic halt();
    @(posedge i_clk);
    halt_req <= 1'b1;
    @(posedge i_clk);
    halt_req <= 1'b0;
  endtask : halt
  task automatic t_regs();
    bus(0, BYTE_SYS_CTL, 8'h00);
    check_val(rd, 16'h0009);
    bus(0, BYTE_HALT_HI, 8'h00);
    check_val(rd, 16'h0078);
    bus(0, 22'h000010, 8'h00);
    check_val(rd, 16'h0000);
    ben <= 4'hE;
    bus(1, BYTE_HALT_LO, 8'hFF);
    ben <= 4'hF;
    bus(0, BYTE_HALT_LO, 8'h00);
    check_val(rd, 16'h0000);
  endtask : t_regs
  task automatic t_modules();
    bus(1, BYTE_HALT_LO, 8'h20);
    bus(1, BYTE_HALT_HI, 8'h07);
    bus(0, BYTE_HALT_HI, 8'h00);
    check_val(rd, 16'h007F);
    check_val(init_seen, 16'h0720);
    check_val(mhalt, 16'h0720);
    check_val(16'(refr_seen), 16'h0001);
    check_val(16'(mode), 16'(MODE_RUN));
    bus(1, BYTE_HALT_LO, 8'h00);
    bus(1, BYTE_HALT_HI, 8'h00);
    @(posedge i_clk);
    check_val(mhalt & 16'h07FF, 16'h0000);
  endtask : t_modules
  task automatic t_sleep();
    halt();
    check_mode(MODE_SLEEP);
    wake_req <= '{any_irq: 1'b1, nmi: 1'b0, ext_irq: 3'h0};
    check_mode(MODE_RUN);
    wake_req <= '0;
  endtask : t_sleep
  // each legal wake line in turn; a plain interrupt must not wake
  task automatic t_swstby();
    bus(1, BYTE_SYS_CTL, 8'hE9);
    for (int i = 0; i < 4; i++) begin
      p6clk <= (i != 3);
      halt();
      check_mode(MODE_SW_STANDBY_PIN_N);
      check_val(16'(ctl.clk_out_high), 16'(i != 3));
      wake_req <= '{any_irq: 1'b1, nmi: 1'b0, ext_irq: 3'h0};
      repeat (20) @(posedge i_clk);
      check_val(16'(mode), 16'(MODE_SW_STANDBY_PIN_N));
      wake_req <= '{any_irq: 1'b1, nmi: i == 3, ext_irq: 3'(1 << i) & 3'h7};
      n = 0;
      while (mode !== MODE_RUN && n < 1100) begin
        @(posedge i_clk);
        n++;
      end
      check_val(16'(n >= 1024 && n <= 1040), 16'h0001);
      wake_req <= '0;
    end
    p6clk <= 1'b1;
    bus(0, BYTE_SYS_CTL, 8'h00);
    check_val(rd, 16'h00E9);
  endtask : t_swstby
  task automatic t_hw();
    bus(1, BYTE_SYS_CTL, 8'h08);
    bus(1, BYTE_HALT_LO, 8'h80);
    check_val(16'(ram_en), 16'h0000);
    halt();
    check_mode(MODE_SLEEP);
    pin_n <= 1'b0;
    check_mode(MODE_HW_STANDBY_PIN_N);
    check_val(16'(ctl.io_hiz), 16'h0001);
    check_val(16'(ctl.clk_out_hiz), 16'h0001);
    pin_n <= 1'b1;
    check_mode(MODE_RUN);
    bus(0, BYTE_HALT_LO, 8'h00);
    check_val(rd, 16'h0000);
  endtask : t_hw
  task automatic close_out();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_modules();
    t_sleep();
    t_swstby();
    t_hw();
    close_out();
  end
endmodule : tb_top
